// file: rtl/tpr_map.vh
`ifndef TPR_MAP_VH
`define TPR_MAP_VH

// register byte addresses on the wishbone bus
`define TPR_ADR_TMR_ROUTE   8'h00
`define TPR_ADR_IRQ_ROUTE   8'h04

// timer routing register field positions (low bit of each field)
`define TPR_TMR5_SEC_IN_LSB 5'd12
`define TPR_TMR5_PRI_OUT_LSB 5'd10
`define TPR_TMR5_PRI_IN_LSB 5'd8
`define TPR_TMR4_SEC_IN_LSB 5'd4
`define TPR_TMR4_PRI_OUT_LSB 5'd2

// writable bits; reserved and out-of-scope bits stay zero
`define TPR_TMR_WMASK       32'h00003f3c
`define TPR_IRQ_WMASK       32'hffffffff

// reset values
`define TPR_TMR_RESET       32'h00000000
`define TPR_IRQ_RESET       32'h00000000

// select codes
`define TPR_SEL_OFF         2'b00
`define TPR_SEL_PIN0_ALT    2'b01
`define TPR_SEL_PIN1        2'b10
`define TPR_SEL_PIN2        2'b11

`define TPR_READ_ZERO       32'h00000000

`endif

// file: rtl/tpr_pin_sel.v
`include "tpr_map.vh"

// three-way input pin selector with a registered result
module tpr_pin_sel (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_reset,
  // selection
  input  wire [1:0] i_sel,
  input  wire       i_block,
  input  wire [2:0] i_pins,
  // routed signal
  output reg        o_sig
);

  reg sig_next;

  // codes 00 and 01 both land on pin 0
  always @* begin
    case (i_sel)
      `TPR_SEL_OFF:      sig_next = i_pins[0];
      `TPR_SEL_PIN0_ALT: sig_next = i_pins[0];
      `TPR_SEL_PIN1:     sig_next = i_pins[1];
      `TPR_SEL_PIN2:     sig_next = i_pins[2];
      default:           sig_next = i_pins[0];
    endcase
    if (i_block) begin
      sig_next = 1'b0;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sig <= 1'b0;
    end else begin
      o_sig <= sig_next;
    end
  end

endmodule

// file: rtl/tpr_route.v
// Our own choices: the Wishbone slave port and the placing of the registers.
`include "tpr_map.vh"

module tpr_route #(
  parameter IRQ_CH = 16
) (
  // clock and resets
  input  wire                  i_sys_clk,
  input  wire                  i_reset,
  input  wire                  i_dstby_reset,
  // wishbone slave
  input  wire                  i_wb_cyc,
  input  wire                  i_wb_stb,
  input  wire                  i_wb_we,
  input  wire [7:0]            i_wb_adr,
  input  wire [3:0]            i_wb_sel,
  input  wire [31:0]           i_wb_dat,
  output reg  [31:0]           o_wb_dat,
  output reg                   o_wb_ack,
  // timer channel 4
  input  wire                  i_tmr4_primary_out,
  input  wire [2:0]            i_tmr4_secondary_pin,
  output reg  [2:0]            o_tmr4_primary_pin_out,
  output reg  [2:0]            o_tmr4_primary_pin_oe,
  output wire                  o_tmr4_secondary_in,
  // timer channel 5
  input  wire                  i_tmr5_primary_out,
  input  wire [2:0]            i_tmr5_primary_pin,
  input  wire [2:0]            i_tmr5_secondary_pin,
  output reg  [2:0]            o_tmr5_primary_pin_out,
  output reg  [2:0]            o_tmr5_primary_pin_oe,
  output wire                  o_tmr5_primary_in,
  output wire                  o_tmr5_secondary_in,
  // external interrupt channels, three alternative pins each
  input  wire [3*IRQ_CH-1:0]   i_irq_pin,
  output wire [IRQ_CH-1:0]     o_irq_in
);

  reg  [31:0] tmr_route_reg;
  reg  [31:0] irq_route_reg;
  reg  [31:0] tmr_route_next;
  reg  [31:0] irq_route_next;
  reg  [31:0] rd_next;
  reg  [31:0] lane_mask;
  reg         wr_pending_reg;
  reg  [7:0]  wr_adr_reg;
  reg  [31:0] wr_dat_reg;
  reg  [3:0]  wr_sel_reg;
  wire        bus_req;
  wire        hit_tmr;
  wire        hit_irq;
  wire [1:0]  tmr5_sec_sel;
  wire [1:0]  tmr5_out_sel;
  wire [1:0]  tmr5_in_sel;
  wire [1:0]  tmr4_sec_sel;
  wire [1:0]  tmr4_out_sel;
  wire        tmr5_in_blocked;
  reg  [2:0]  tmr4_oe_next;
  reg  [2:0]  tmr5_oe_next;

  assign bus_req = i_wb_cyc & i_wb_stb;
  assign hit_tmr = (i_wb_adr == `TPR_ADR_TMR_ROUTE);
  assign hit_irq = (i_wb_adr == `TPR_ADR_IRQ_ROUTE);

  // ---------------------------------------------------------------
  // bus handshake: ack one cycle after the request, dropped after one
  // cycle. the write lands at the edge where the master samples ack,
  // so the stored value never runs ahead of the bus transfer.
  // ---------------------------------------------------------------
  always @* begin
    rd_next = `TPR_READ_ZERO;
    if (hit_tmr) begin
      rd_next = tmr_route_reg & `TPR_TMR_WMASK;
    end else if (hit_irq) begin
      rd_next = irq_route_reg;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset || i_dstby_reset) begin
      o_wb_ack       <= 1'b0;
      o_wb_dat       <= `TPR_READ_ZERO;
      wr_pending_reg <= 1'b0;
      wr_adr_reg     <= 8'h00;
      wr_dat_reg     <= `TPR_READ_ZERO;
      wr_sel_reg     <= 4'h0;
    end else begin
      o_wb_ack       <= bus_req & ~o_wb_ack;
      wr_pending_reg <= bus_req & ~o_wb_ack & i_wb_we;
      wr_adr_reg     <= i_wb_adr;
      wr_dat_reg     <= i_wb_dat;
      wr_sel_reg     <= i_wb_sel;
      if (bus_req & ~o_wb_ack & ~i_wb_we) begin
        o_wb_dat <= rd_next;
      end else if (!bus_req) begin
        // read data holds until an edge sees the request dropped
        o_wb_dat <= `TPR_READ_ZERO;
      end
    end
  end

  // byte lanes to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      always @* begin
        lane_mask[8*lane+7:8*lane] = {8{wr_sel_reg[lane]}};
      end
    end
  endgenerate

  // commit at the ack edge, only if the master still holds the request
  always @* begin
    tmr_route_next = tmr_route_reg;
    irq_route_next = irq_route_reg;
    if (wr_pending_reg && o_wb_ack && bus_req) begin
      if (wr_adr_reg == `TPR_ADR_TMR_ROUTE) begin
        // reserved pairs are never stored, so they read back zero
        tmr_route_next = (tmr_route_reg & ~(lane_mask & `TPR_TMR_WMASK)) |
                         (wr_dat_reg & lane_mask & `TPR_TMR_WMASK);
      end else if (wr_adr_reg == `TPR_ADR_IRQ_ROUTE) begin
        irq_route_next = (irq_route_reg & ~(lane_mask & `TPR_IRQ_WMASK)) |
                         (wr_dat_reg & lane_mask & `TPR_IRQ_WMASK);
      end
    end
  end

  // deep-standby reset is deliberately absent here
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      tmr_route_reg <= `TPR_TMR_RESET;
      irq_route_reg <= `TPR_IRQ_RESET;
    end else begin
      tmr_route_reg <= tmr_route_next;
      irq_route_reg <= irq_route_next;
    end
  end

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  assign tmr5_sec_sel = tmr_route_reg[`TPR_TMR5_SEC_IN_LSB +: 2];
  assign tmr5_out_sel = tmr_route_reg[`TPR_TMR5_PRI_OUT_LSB +: 2];
  assign tmr5_in_sel  = tmr_route_reg[`TPR_TMR5_PRI_IN_LSB +: 2];
  assign tmr4_sec_sel = tmr_route_reg[`TPR_TMR4_SEC_IN_LSB +: 2];
  assign tmr4_out_sel = tmr_route_reg[`TPR_TMR4_PRI_OUT_LSB +: 2];

  // odd primary pin is not bidirectional: output wins
  assign tmr5_in_blocked = (tmr5_out_sel != `TPR_SEL_OFF);

  // ---------------------------------------------------------------
  // primary output routing; one pin enabled at most per channel.
  // the timer value is gated so an unselected pin shows a quiet zero.
  // ---------------------------------------------------------------
  always @* begin
    tmr4_oe_next = 3'b000;
    tmr5_oe_next = 3'b000;
    case (tmr4_out_sel)
      `TPR_SEL_OFF:      tmr4_oe_next = 3'b000;
      `TPR_SEL_PIN0_ALT: tmr4_oe_next = 3'b001;
      `TPR_SEL_PIN1:     tmr4_oe_next = 3'b010;
      `TPR_SEL_PIN2:     tmr4_oe_next = 3'b100;
      default:           tmr4_oe_next = 3'b000;
    endcase
    case (tmr5_out_sel)
      `TPR_SEL_OFF:      tmr5_oe_next = 3'b000;
      `TPR_SEL_PIN0_ALT: tmr5_oe_next = 3'b001;
      `TPR_SEL_PIN1:     tmr5_oe_next = 3'b010;
      `TPR_SEL_PIN2:     tmr5_oe_next = 3'b100;
      default:           tmr5_oe_next = 3'b000;
    endcase
  end

  // channel 4 primary is output only and has no input path
  always @(posedge i_sys_clk) begin
    if (i_reset || i_dstby_reset) begin
      o_tmr4_primary_pin_oe  <= 3'b000;
      o_tmr4_primary_pin_out <= 3'b000;
      o_tmr5_primary_pin_oe  <= 3'b000;
      o_tmr5_primary_pin_out <= 3'b000;
    end else begin
      o_tmr4_primary_pin_oe  <= tmr4_oe_next;
      o_tmr4_primary_pin_out <= tmr4_oe_next & {3{i_tmr4_primary_out}};
      o_tmr5_primary_pin_oe  <= tmr5_oe_next;
      o_tmr5_primary_pin_out <= tmr5_oe_next & {3{i_tmr5_primary_out}};
    end
  end

  // ---------------------------------------------------------------
  // input routing. the pad level is taken as is, except at the channel 5
  // primary input, which reads zero while a channel 5 output pin is selected;
  // elsewhere whatever another function drives on a shared pin reaches the timer as feedback.
  // ---------------------------------------------------------------
  tpr_pin_sel u_tmr4_sec (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_sel     (tmr4_sec_sel),
    .i_block   (1'b0),
    .i_pins    (i_tmr4_secondary_pin),
    .o_sig     (o_tmr4_secondary_in)
  );

  tpr_pin_sel u_tmr5_sec (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_sel     (tmr5_sec_sel),
    .i_block   (1'b0),
    .i_pins    (i_tmr5_secondary_pin),
    .o_sig     (o_tmr5_secondary_in)
  );

  tpr_pin_sel u_tmr5_pri (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_sel     (tmr5_in_sel),
    .i_block   (tmr5_in_blocked),
    .i_pins    (i_tmr5_primary_pin),
    .o_sig     (o_tmr5_primary_in)
  );

  // one selector per interrupt channel, field n at bits 2n+1:2n
  genvar ch;
  generate
    for (ch = 0; ch < IRQ_CH; ch = ch + 1) begin : g_irq
      tpr_pin_sel u_irq_sel (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_sel     (irq_route_reg[2*ch+1:2*ch]),
        .i_block   (1'b0),
        .i_pins    (i_irq_pin[3*ch+2:3*ch]),
        .o_sig     (o_irq_in[ch])
      );
    end
  endgenerate

endmodule

// file: verif/tpr_route_monitor.sv
module tpr_route_monitor #(
  parameter IRQ_CH = 16
) (
  input wire                i_sys_clk,
  input wire                i_reset,
  input wire                i_dstby_reset,
  input wire                i_wb_cyc,
  input wire                i_wb_stb,
  input wire                i_wb_we,
  input wire [7:0]          i_wb_adr,
  input wire [31:0]         o_wb_dat,
  input wire                o_wb_ack,
  input wire                i_tmr4_primary_out,
  input wire [2:0]          i_tmr4_secondary_pin,
  input wire [2:0]          o_tmr4_primary_pin_out,
  input wire [2:0]          o_tmr4_primary_pin_oe,
  input wire                o_tmr4_secondary_in,
  input wire [2:0]          o_tmr5_primary_pin_oe,
  input wire                o_tmr5_primary_in,
  input wire [3*IRQ_CH-1:0] i_irq_pin,
  input wire [IRQ_CH-1:0]   o_irq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // standby reset also clears the bus flops
  AST_ACK_NEXT: assert property (disable iff (i_reset || i_dstby_reset)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack missing");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  AST_RSV_ZERO: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h00 |->
    (o_wb_dat & 32'hffffc0c3) == 32'h00000000) else $error("reserved bits set");
  AST_OE4_ONE: assert property ($onehot0(o_tmr4_primary_pin_oe)) else $error("ch4 on two pins");
  AST_OE5_ONE: assert property ($onehot0(o_tmr5_primary_pin_oe)) else $error("ch5 on two pins");
  AST_OUT4_GATE: assert property ((o_tmr4_primary_pin_out & ~o_tmr4_primary_pin_oe) == 3'h0)
    else $error("undriven pin high");
  AST_OUT4_FOLLOW: assert property (|o_tmr4_primary_pin_oe |->
    (|o_tmr4_primary_pin_out) == $past(i_tmr4_primary_out)) else $error("ch4 output value wrong");
  AST_IN5_BLOCK: assert property (|o_tmr5_primary_pin_oe |-> !o_tmr5_primary_in) else $error("ch5 in open");
  AST_SEC4_HI: assert property (i_tmr4_secondary_pin == 3'h7 |=> o_tmr4_secondary_in) else $error("ch4 in low");
  AST_IRQ_LO: assert property (~|i_irq_pin |=> ~|o_irq_in) else $error("irq in stuck high");
  cover property (o_wb_ack && i_wb_we);
  cover property (|o_tmr5_primary_pin_oe);
  cover property (i_dstby_reset);
endmodule

bind tpr_route tpr_route_monitor #(.IRQ_CH(IRQ_CH)) u_tpr_route_monitor (.i_sys_clk, .i_reset, .i_dstby_reset,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_tmr4_primary_out, .i_tmr4_secondary_pin,
  .o_tmr4_primary_pin_out, .o_tmr4_primary_pin_oe, .o_tmr4_secondary_in, .o_tmr5_primary_pin_oe,
  .o_tmr5_primary_in, .i_irq_pin, .o_irq_in);

// file: verif/tpr_pins_model.sv
module tpr_pins_model (
  input  wire        i_sys_clk,
  input  wire [2:0]  i_lvl,
  input  wire [2:0]  i_t5_oe,
  input  wire [2:0]  i_t5_out,
  output reg         o_t4_drv,
  output reg         o_t5_drv,
  output wire [2:0]  o_t4_sec,
  output wire [2:0]  o_t5_sec,
  output wire [2:0]  o_t5_pri,
  output wire [47:0] o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_t4_drv = 1'b0;
  initial o_t5_drv = 1'b1;
  // timers toggle freely so a stuck output path shows
  always @(posedge i_sys_clk) begin
    o_t4_drv <= ~o_t4_drv;
    o_t5_drv <= ~o_t5_drv;
  end
  // pads set to digital, routed, other drivers off
  assign o_t4_sec = i_lvl;
  assign o_t5_sec = i_lvl;
  // a driven pad reads its own level back
  assign o_t5_pri = (i_t5_oe & i_t5_out) | (~i_t5_oe & i_lvl);
  assign o_irq = {16{i_lvl}};
endmodule

// file: verif/tpr_route_test.sv
module tpr_route_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        dstby = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [2:0]  lvl = 3'h0;
  logic [3:0]  sel = 4'hf;
  wire  [31:0] dat;
  wire         ack, t4d, t5d, t4si, t5si, t5pi;
  wire  [2:0]  t4s, t5s, t5p, t4o, t4e, t5o, t5e;
  wire  [47:0] irqp;
  wire  [15:0] irq;
  int          fails = 0;
  int          tests_run = 0;
  always #20 clk = ~clk;
  tpr_route u_tpr_route (.i_sys_clk(clk), .i_reset(rst), .i_dstby_reset(dstby), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack),
    .i_tmr4_primary_out(t4d), .i_tmr4_secondary_pin(t4s), .o_tmr4_primary_pin_out(t4o),
    .o_tmr4_primary_pin_oe(t4e), .o_tmr4_secondary_in(t4si), .i_tmr5_primary_out(t5d), .i_tmr5_primary_pin(t5p),
    .i_tmr5_secondary_pin(t5s), .o_tmr5_primary_pin_out(t5o), .o_tmr5_primary_pin_oe(t5e),
    .o_tmr5_primary_in(t5pi), .o_tmr5_secondary_in(t5si), .i_irq_pin(irqp), .o_irq_in(irq));
  tpr_pins_model u_tpr_pins_model (.i_sys_clk(clk), .i_lvl(lvl), .i_t5_oe(t5e), .i_t5_out(t5o), .o_t4_drv(t4d),
    .o_t5_drv(t5d), .o_t4_sec(t4s), .o_t5_sec(t5s), .o_t5_pri(t5p), .o_irq(irqp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // routed outputs lag the select by a register and a sample flop
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    check({t4e, t5e}, 6'h00);
    wb(1'b1, 8'h00, 32'hffffffff);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h00003f3c);
    wb(1'b1, 8'h00, 32'h00001514);
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h00001514);
    wb(1'b1, 8'h04, 32'h5555aaaa);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h5555aaaa);
    // only byte lane 1 may change
    sel <= 4'h2;
    wb(1'b1, 8'h04, 32'hffffffff);
    sel <= 4'hf;
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h5555ffaa);
    wb(1'b1, 8'h04, 32'h5555aaaa);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    $display("register access done");
  endtask
  task automatic t_inputs();
    logic [1:0] c;
    logic       e;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wb(1'b1, 8'h00, {18'h0, c, 2'b00, c, 2'b00, c, 4'h0});
      wb(1'b1, 8'h04, {16{c}});
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        lvl <= (k == 3) ? 3'b111 : 3'b001 << k;
        settle();
        e = (k == 3) || (k == ((c == 2'b11) ? 2 : (c == 2'b10) ? 1 : 0));
        check({t4si, t5si, t5pi, irq}, {19{e}});
      end
    end
    $display("input routing done");
  endtask
  task automatic t_outputs();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wb(1'b1, 8'h00, {20'h0, c, 6'h0, c, 2'b00});
      settle();
      check({t4e, t5e}, {2{i == 0 ? 3'b000 : 3'b001 << (i - 1)}});
      // timers toggle each cycle, so the pin shows the level before the last edge
      check({t4o, t5o}, {t4e & {3{~t4d}}, t5e & {3{~t5d}}});
      check(t5pi, i == 0);
    end
    $display("output routing done");
  endtask
  task automatic t_dstby();
    wb(1'b1, 8'h00, 32'h00001514);
    wb(1'b1, 8'h04, 32'ha5a5a5a5);
    dstby <= 1'b1;
    repeat (2) @(posedge clk);
    dstby <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h00001514);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'ha5a5a5a5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    $display("standby reset done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  initial begin
    #400000;
    fails++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_inputs();
    t_outputs();
    t_dstby();
    final_report();
  end
endmodule
